// file: shared/uart_tx_pkg.sv
/*
  Constants for the transmit channel: register map, field positions,
  reset values and bit timing counts.
  Assumes a 32-bit APB slave with byte addresses of aligned words.
*/
package uart_tx_pkg;

  // register map, byte addresses
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  MODE_OFF        = 8'h00;
  localparam logic [7:0]  CMD_OFF         = 8'h04;
  localparam logic [7:0]  STATUS_OFF      = 8'h08;
  localparam logic [7:0]  DATA_OFF        = 8'h0C;
  localparam logic [7:0]  DIV_OFF         = 8'h10;

  // mode_reg_two fields
  localparam int          MODE_W          = 11;
  localparam int          M_LEN_LSB       = 0;   // 2 bits: 5,6,7,8 data bits
  localparam int          M_PAR_EN        = 2;
  localparam int          M_PAR_ODD       = 3;
  localparam int          M_CTS_EN        = 4;
  localparam int          M_RTS_AUTO      = 5;
  localparam int          M_STOP_LSB      = 6;   // 2 bits: 1, 1.5, 2 stop bits
  localparam int          M_X1            = 8;
  localparam int          M_IRQ_EN        = 9;
  localparam int          M_RTS_LEVEL     = 10;
  localparam logic [10:0] MODE_RESET      = 11'h003;

  // command_reg fields, write-only pulses
  localparam int          C_ENABLE        = 0;
  localparam int          C_DISABLE       = 1;
  localparam int          C_RESET         = 2;
  localparam int          C_BRK_START     = 3;
  localparam int          C_BRK_STOP      = 4;
  localparam int          CMD_W           = 5;

  // status_reg fields
  localparam int          S_SPACE         = 0;
  localparam int          S_EMPTY         = 1;
  localparam int          S_ENABLED       = 2;
  localparam int          S_BREAK         = 3;
  localparam int          S_BUSY          = 4;
  localparam int          S_CTS_N         = 5;
  localparam int          S_COUNT_LSB     = 8;

  // bit timing
  localparam logic [15:0] DIV_RESET       = 16'h0000;
  localparam logic [5:0]  TICKS_16X       = 6'h10;   // ticks per bit in 16x mode
  localparam logic [5:0]  TICKS_STOP_1P5  = 6'h18;
  localparam logic [5:0]  TICKS_STOP_2    = 6'h20;
  localparam logic [5:0]  ABORT_16X       = 6'h03;   // 3/16 bit time
  localparam int          TXQ_DEPTH       = 8;
  localparam int          CHAR_W          = 8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b011,
    ST_PARITY = 3'b010,
    ST_STOP   = 3'b110
  } tx_state_t;

endpackage

// file: shared/queue_if.sv
/*
  Carrier between the channel and its character queue.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface queue_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
);
  logic                         push;
  logic [WIDTH-1:0]             push_data;
  logic                         pop;
  logic                         flush;
  logic [WIDTH-1:0]             head;
  logic                         avail;
  logic                         full;
  logic [$clog2(DEPTH+1)-1:0]   count;

  modport store (input push, push_data, pop, flush, output head, avail, full, count);
  modport user  (output push, push_data, pop, flush, input head, avail, full, count);
endinterface

// file: design/tx_queue_mem.sv
/*
  Character queue for the transmit channel, head word out of a register.
  Assumes the user pops only while avail is high and pushes only while
  full is low.
*/
`timescale 1ns/1ps
module tx_queue_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // queue side
  queue_if.store        q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic [WIDTH-1:0] head_q;
  logic             avail_q;
  logic             do_push;
  logic             do_pop;

  assign do_push = q.push && (count_q != CW'(DEPTH));
  assign do_pop  = q.pop && avail_q;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_ptr_q] <= q.push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (q.flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_push) wr_ptr_q <= step(wr_ptr_q);
      if (do_pop)  rd_ptr_q <= step(rd_ptr_q);
      count_q <= count_q + CW'(do_push) - CW'(do_pop);
    end
  end

  // head and avail lag the pointers by one cycle together, so they always agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_q  <= '0;
      avail_q <= 1'b0;
    end else begin
      head_q  <= mem[rd_ptr_q];
      avail_q <= (count_q != '0) && !do_pop && !q.flush;
    end
  end

  assign q.head  = head_q;
  assign q.avail = avail_q;
  assign q.full  = (count_q == CW'(DEPTH));
  assign q.count = count_q;
endmodule

// file: design/uart_transmit_channel.sv
/*
  One asynchronous transmit channel behind an APB register slave:
  character queue, bit timing, framing, break, flow control and
  request-to-send turnaround.
  Assumes a single pclk domain; clear_to_send_in_n is synchronous to pclk.
*/
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// How it works
// (RULE_01) space flag: enabled and queue not full
// (RULE_02) enabling sets space and empty flags
// (RULE_03) queue write clears empty, sending resumes
// (RULE_04) empty sets after last stop or re-enable
// (RULE_05) queue head moves to shifter when idle
// (RULE_06) queue writes ignored while disabled
// (RULE_07) start, data lsb first, parity, stops
// (RULE_08) idle line high, empty set after stops
// (RULE_09) disable drains shifter and queue first
// (RULE_10) disable clears status flags at once
// (RULE_11) reset halts, flushes, clears all status; break_q is kept, so a running break stays on
// (RULE_12) host must re-enable after a reset
// (RULE_13) break forces line low until stopped
// (RULE_14) cts option gates each character
// (RULE_15) cts checked at character start only
// (RULE_16) auto request-to-send marks end of message
// (RULE_17) space flag drives interrupt pins
// (RULE_18) early disable after empty load drops char
// (RULE_19) transfer in start bit, space after it
// (RULE_20) host waits for space before disabling
// (RULE_21) 16x mode: sixteen ticks per bit
// (RULE_22) queue holds eight characters
// (RULE_23) commands act the clock after the write
module uart_transmit_channel
  import uart_tx_pkg::*;
#(
  parameter int DEPTH = TXQ_DEPTH
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // serial side
  output logic                     serial_out,
  input  wire logic                clear_to_send_in_n,
  output logic                     request_to_send_out_n,
  // interrupt pins
  output logic                     out_pin_zero,
  output logic                     irq_out_n
);
  localparam int CW = $clog2(DEPTH+1);

  queue_if #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) q ();

  tx_queue_mem #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_queue (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase, answer registered in setup

  logic              pready_q;
  logic [31:0]       prdata_q;
  logic              pslverr_q;
  logic              setup;
  logic              wr;
  logic              mapped;
  logic [MODE_W-1:0] mode_q;
  logic [15:0]       div_q;
  logic [CMD_W-1:0]  cmd_q;
  logic              enable_q;
  logic              enable_d;
  logic              break_q;
  logic              empty_q;
  logic              space_q;
  logic [31:0]       status;
  tx_state_t         state_q;

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pready_q && pwrite;
  assign mapped = (paddr == MODE_OFF) || (paddr == CMD_OFF) || (paddr == STATUS_OFF) ||
                  (paddr == DATA_OFF) || (paddr == DIV_OFF);

  always_comb begin
    status                           = '0;
    status[S_SPACE]                  = space_q;
    status[S_EMPTY]                  = empty_q;
    status[S_ENABLED]                = enable_q;
    status[S_BREAK]                  = break_q;
    status[S_BUSY]                   = (state_q != ST_IDLE);
    status[S_CTS_N]                  = clear_to_send_in_n;
    status[S_COUNT_LSB +: CW]        = q.count;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite) begin
        case (paddr)
          MODE_OFF:   prdata_q <= 32'(mode_q);
          STATUS_OFF: prdata_q <= status;
          DIV_OFF:    prdata_q <= 32'(div_q);
          default:    prdata_q <= '0;
        endcase
      end else begin
        prdata_q <= '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RESET;
      div_q  <= DIV_RESET;
    end else if (wr && paddr == MODE_OFF) begin
      mode_q <= pwdata[MODE_W-1:0];
    end else if (wr && paddr == DIV_OFF) begin
      div_q <= pwdata[15:0];
    end
  end

  // commands are registered so each acts on the clock after its write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
    end else begin
      cmd_q <= (wr && paddr == CMD_OFF) ? pwdata[CMD_W-1:0] : '0;  // [RULE_23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel control

  logic cmd_en;
  logic cmd_dis;
  logic cmd_rst;

  assign cmd_en  = cmd_q[C_ENABLE];
  assign cmd_dis = cmd_q[C_DISABLE];
  assign cmd_rst = cmd_q[C_RESET];

  always_comb begin
    enable_d = enable_q;
    if (cmd_rst || cmd_dis) begin
      enable_d = 1'b0;  // [RULE_10] [RULE_11]
    end else if (cmd_en) begin
      enable_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_q <= 1'b0;
    end else if (cmd_q[C_BRK_START]) begin
      break_q <= 1'b1;  // [RULE_13]
    end else if (cmd_q[C_BRK_STOP]) begin
      break_q <= 1'b0;  // [RULE_13]
    end
  end

  // writes while disabled or full are dropped without an error answer
  assign q.push      = wr && (paddr == DATA_OFF) && enable_q && !q.full;  // [RULE_06] [RULE_22]
  assign q.push_data = pwdata[CHAR_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // bit clock: tick every div_q+1 cycles

  logic [15:0] baud_cnt_q;
  logic        tick_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (baud_cnt_q == '0);
      baud_cnt_q <= (baud_cnt_q == '0) ? div_q : baud_cnt_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // framing state machine

  logic        x1;
  logic [5:0]  bit_units;
  logic [5:0]  stop_units;
  logic [5:0]  unit_q;
  logic [5:0]  last_unit;
  logic        bit_end;
  logic [2:0]  bitn_q;
  logic [2:0]  last_bit;
  logic [7:0]  shreg_q;
  logic        par_q;
  logic [7:0]  mask;
  logic        cts_ok;
  logic        start_frame;
  logic        frame_done;
  logic        abort;
  logic        was_empty_q;

  assign x1        = mode_q[M_X1];
  assign bit_units = x1 ? 6'h01 : TICKS_16X;  // [RULE_21]
  assign last_bit  = 3'h4 + {1'b0, mode_q[M_LEN_LSB +: 2]};
  assign mask      = 8'hFF >> (3'h7 - last_bit);

  always_comb begin
    case (mode_q[M_STOP_LSB +: 2])
      2'h0:    stop_units = bit_units;
      2'h1:    stop_units = x1 ? 6'h02 : TICKS_STOP_1P5;
      default: stop_units = x1 ? 6'h02 : TICKS_STOP_2;
    endcase
  end

  assign last_unit   = ((state_q == ST_STOP) ? stop_units : bit_units) - 6'h01;
  assign bit_end     = tick_q && (unit_q == last_unit);
  assign frame_done  = (state_q == ST_STOP) && bit_end;
  assign cts_ok      = !mode_q[M_CTS_EN] || !clear_to_send_in_n;  // [RULE_14] [RULE_15]
  // queue head loads into the shifter only between characters
  assign start_frame = !cmd_rst && q.avail && cts_ok && tick_q &&
                       ((state_q == ST_IDLE) || frame_done);  // [RULE_05] [RULE_09]
  assign q.pop       = start_frame;  // [RULE_19]
  // a disable too soon after loading an empty channel kills that character
  assign abort       = was_empty_q && cmd_dis && ((state_q == ST_IDLE) ||
                       ((state_q == ST_START) && (x1 || unit_q < ABORT_16X)));  // [RULE_18]
  assign q.flush     = cmd_rst || abort;  // [RULE_11] [RULE_18]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      unit_q  <= '0;
      bitn_q  <= '0;
      shreg_q <= '0;
      par_q   <= 1'b0;
    end else if (cmd_rst || abort) begin
      state_q <= ST_IDLE;  // [RULE_11]
      unit_q  <= '0;
    end else if (start_frame) begin
      state_q <= ST_START;  // [RULE_03] [RULE_07]
      unit_q  <= '0;
      shreg_q <= q.head & mask;
      par_q   <= ^(q.head & mask) ^ mode_q[M_PAR_ODD];
    end else if (tick_q) begin
      unit_q <= bit_end ? 6'h00 : unit_q + 6'h01;
      if (bit_end) begin
        case (state_q)
          ST_START: begin
            state_q <= ST_DATA;
            bitn_q  <= '0;
          end
          ST_DATA: begin
            shreg_q <= {1'b0, shreg_q[7:1]};  // [RULE_07]
            bitn_q  <= bitn_q + 3'h1;
            if (bitn_q == last_bit) begin
              state_q <= mode_q[M_PAR_EN] ? ST_PARITY : ST_STOP;
            end
          end
          ST_PARITY: state_q <= ST_STOP;
          ST_STOP:   state_q <= ST_IDLE;  // [RULE_08]
          default:   state_q <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      was_empty_q <= 1'b0;
    end else if (q.push && empty_q) begin
      was_empty_q <= 1'b1;
    end else if (cmd_rst || abort || (state_q == ST_START && bit_end) || state_q == ST_STOP) begin
      was_empty_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  logic [CW:0] occupied;

  // the character in its start bit still holds a slot, so space returns after it
  assign occupied = {1'b0, q.count} + {{CW{1'b0}}, (state_q == ST_START)};  // [RULE_19]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      space_q <= 1'b0;
    end else begin
      space_q <= enable_d && (occupied < (CW+1)'(DEPTH));  // [RULE_01] [RULE_02] [RULE_22]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_q <= 1'b0;
    end else if (cmd_rst || cmd_dis) begin
      empty_q <= 1'b0;  // [RULE_10] [RULE_11]
    end else if (cmd_en && !enable_q) begin
      empty_q <= 1'b1;  // [RULE_02] [RULE_04]
    end else if (q.push) begin
      empty_q <= 1'b0;  // [RULE_03]
    end else if (frame_done && q.count == '0 && enable_q) begin
      empty_q <= 1'b1;  // [RULE_04] [RULE_08]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  logic txd_q;
  logic rts_n_q;
  logic pin0_q;
  logic irq_n_q;
  logic busy;

  assign busy = (state_q != ST_IDLE) || q.avail || (q.count != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_q <= 1'b1;
    end else if (break_q) begin
      txd_q <= 1'b0;  // [RULE_13]
    end else begin
      case (state_q)
        ST_START:  txd_q <= 1'b0;
        ST_DATA:   txd_q <= shreg_q[0];
        ST_PARITY: txd_q <= par_q;
        default:   txd_q <= 1'b1;  // [RULE_08]
      endcase
    end
  end

  // auto mode: low while anything is left to send, high marks end of message
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n_q <= 1'b1;
    end else if (mode_q[M_RTS_AUTO]) begin
      rts_n_q <= !busy;  // [RULE_16]
    end else begin
      rts_n_q <= !mode_q[M_RTS_LEVEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_q  <= 1'b1;
      irq_n_q <= 1'b1;
    end else begin
      pin0_q  <= !(space_q && mode_q[M_IRQ_EN]);  // [RULE_17]
      irq_n_q <= !(space_q && mode_q[M_IRQ_EN]);  // [RULE_17]
    end
  end

  assign pready                = pready_q;
  assign prdata                = prdata_q;
  assign pslverr               = pslverr_q;
  assign serial_out            = txd_q;
  assign request_to_send_out_n = rts_n_q;
  assign out_pin_zero          = pin0_q;
  assign irq_out_n             = irq_n_q;
endmodule

// file: test/tx_channel_properties.sv
/*
  Port checker for the transmit channel, bound to its top module.
  Assumes mode and break state change only through APB writes.
*/
`timescale 1ns/1ps
module tx_channel_properties
  import uart_tx_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // serial and pins
  input wire logic              serial_out,
  input wire logic              clear_to_send_in_n,
  input wire logic              request_to_send_out_n,
  input wire logic              out_pin_zero,
  input wire logic              irq_out_n
);
  logic [MODE_W-1:0] mode_q;
  logic              brk_q;
  logic              wr_ok;
  logic              mapped;
  logic              rst_cmd;

  assign wr_ok   = psel && penable && pready && pwrite;
  assign mapped  = paddr inside {MODE_OFF, CMD_OFF, STATUS_OFF, DATA_OFF, DIV_OFF};
  assign rst_cmd = wr_ok && paddr == CMD_OFF && pwdata[C_RESET] && !pwdata[C_BRK_START];

  // shadow copies let the pin relations be judged without seeing the body
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= MODE_RESET;
    else if (wr_ok && paddr == MODE_OFF) mode_q <= pwdata[MODE_W-1:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) brk_q <= 1'b0;
    else if (wr_ok && paddr == CMD_OFF && pwdata[C_BRK_START]) brk_q <= 1'b1;
    else if (wr_ok && paddr == CMD_OFF && pwdata[C_BRK_STOP]) brk_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_pready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped address");
  a_prdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_irq_pins: assert property (out_pin_zero == irq_out_n)
    else $error("interrupt pins disagree");
  a_irq_gated: assert property (!mode_q[M_IRQ_EN] && $stable(mode_q) |-> out_pin_zero)
    else $error("interrupt while not enabled");
  a_rts_manual: assert property (!mode_q[M_RTS_AUTO] && $stable(mode_q)
    |-> request_to_send_out_n == !mode_q[M_RTS_LEVEL])
    else $error("manual rts level wrong");
  a_break_low: assert property (brk_q && $past(brk_q, 3) |-> !serial_out)
    else $error("break not driving line low");
  a_reset_halt: assert property (rst_cmd && !brk_q |-> ##4 serial_out [*2])
    else $error("line not idle after reset command");

  c_data_write: cover property (wr_ok && paddr == DATA_OFF);
  c_frame_start: cover property ($fell(serial_out) && !brk_q);
  c_break_on: cover property (brk_q && !serial_out);
endmodule

bind uart_transmit_channel tx_channel_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .serial_out(serial_out), .clear_to_send_in_n(clear_to_send_in_n),
  .request_to_send_out_n(request_to_send_out_n), .out_pin_zero(out_pin_zero),
  .irq_out_n(irq_out_n)
);

// file: test/serial_receiver_model.sv
/*
  Remote receiver: eight data bits, no parity, one stop bit.
  Assumes bit_cycles is the pclk count of one bit and is even.
*/
`timescale 1ns/1ps
module serial_receiver_model (
  // clock
  input  wire logic        pclk,
  // serial side
  input  wire logic        serial_out,
  input  wire logic        stall,
  input  wire logic [15:0] bit_cycles,
  output logic             clear_to_send_in_n,
  // received characters
  output logic             rx_valid,
  output logic [7:0]       rx_data
);
  logic [7:0] shift;

  assign clear_to_send_in_n = stall;

  // samples mid-bit; a low stop bit (break) is thrown away
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    forever begin
      @(negedge serial_out);
      repeat (bit_cycles / 2) @(posedge pclk);
      if (serial_out === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bit_cycles) @(posedge pclk);
          shift[i] = serial_out;
        end
        repeat (bit_cycles) @(posedge pclk);
        if (serial_out === 1'b1) begin
          rx_data  <= shift;
          rx_valid <= 1'b1;
          @(posedge pclk);
          rx_valid <= 1'b0;
        end
      end
    end
  end
endmodule

// file: test/uart_transmit_channel_test.sv
/*
  Register-level tests of the transmit channel with a remote receiver.
  Assumes APB answers within a bounded number of cycles.
*/
`timescale 1ns/1ps
module uart_transmit_channel_test;
  import uart_tx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
  logic serial_out, cts_n, rts_n, op0, irq_n, rx_valid, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] bitc;
  logic [7:0] rx_data;
  logic [7:0] rxq[$];
  int num_errors, checks, lows;
  localparam logic [31:0] RDY = (1 << S_SPACE) | (1 << S_EMPTY) | (1 << S_ENABLED);

  uart_transmit_channel #(.DEPTH(TXQ_DEPTH)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .serial_out(serial_out),
    .clear_to_send_in_n(cts_n), .request_to_send_out_n(rts_n), .out_pin_zero(op0),
    .irq_out_n(irq_n));
  serial_receiver_model far (.pclk(pclk), .serial_out(serial_out), .stall(stall),
    .bit_cycles(bitc), .clear_to_send_in_n(cts_n), .rx_valid(rx_valid), .rx_data(rx_data));

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (rx_valid === 1'b1) rxq.push_back(rx_data);

  ////////////////////////////////////////////////////////////
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check1(1'b0, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
  task automatic rd32(input logic [7:0] a); xfer(1'b0, a, 32'h0000_0000); endtask
  task automatic cycles(input int n); repeat (n) @(posedge pclk); endtask
  task automatic count_lows(input int n);
    lows = 0;
    repeat (n) begin @(posedge pclk); if (serial_out !== 1'b1) lows++; end
  endtask
  task automatic wait_fall;
    int n;
    n = 0;
    while (serial_out !== 1'b0 && n < 2000) begin @(posedge pclk); n++; end
  endtask
  task automatic expect_rx(input logic [7:0] d);
    int n;
    n = 0;
    while (rxq.size() == 0 && n < 3000) begin @(posedge pclk); n++; end
    if (rxq.size() == 0) check1(1'b0, 1'b1);
    else check32({24'h0, rxq.pop_front()}, {24'h0, d});
  endtask
  task automatic wait_empty;
    int n;
    n = 0;
    do begin rd32(STATUS_OFF); n++; end while (rd[S_EMPTY] !== 1'b1 && n < 400);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    conclude();
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    stall = 0; bitc = 16'h0010; num_errors = 0; checks = 0;
    cycles(3);
    presetn <= 1'b1;
    cycles(1);
    rd32(MODE_OFF); check32(rd, {21'h0, MODE_RESET});
    rd32(8'h14); check1(er, 1'b1);
    rd32(STATUS_OFF); check32(rd, 32'h0000_0000);
    wr32(DATA_OFF, 32'h0000_0011);
    wr32(CMD_OFF, 1 << C_ENABLE);
    rd32(STATUS_OFF); check32(rd, RDY);
    $display("test enable done");
    wr32(MODE_OFF, MODE_RESET | (1 << M_RTS_AUTO) | (1 << M_IRQ_EN));
    cycles(2); check1(op0, 1'b0);
    wr32(DATA_OFF, 32'h0000_00A5);
    wr32(DATA_OFF, 32'h0000_003C);
    rd32(STATUS_OFF); check1(rd[S_EMPTY], 1'b0);
    check1(rts_n, 1'b0);
    expect_rx(8'hA5);
    expect_rx(8'h3C);
    wait_empty; check1(serial_out, 1'b1);
    check1(rts_n, 1'b1);
    $display("test frames done");
    wr32(MODE_OFF, MODE_RESET | (1 << M_CTS_EN));
    stall <= 1'b1;
    for (int i = 0; i < 9; i++) wr32(DATA_OFF, 32'h40 + i);
    count_lows(100); check32(lows, 0);
    rd32(STATUS_OFF);
    check32(rd[11:0], (TXQ_DEPTH << S_COUNT_LSB) | (1 << S_ENABLED) | (1 << S_CTS_N));
    stall <= 1'b0;
    wait_fall; cycles(20);
    stall <= 1'b1;
    expect_rx(8'h40);
    count_lows(200); check32(lows, 0);
    stall <= 1'b0;
    for (int i = 1; i < 8; i++) expect_rx(8'h40 + i);
    wait_empty; check32(rxq.size(), 0);
    $display("test flow done");
    wr32(MODE_OFF, MODE_RESET);
    wr32(DATA_OFF, 32'h0000_005A);
    wr32(DATA_OFF, 32'h0000_00C3);
    wait_fall; cycles(40);
    wr32(CMD_OFF, 1 << C_DISABLE);
    rd32(STATUS_OFF); check32(rd[2:0], 3'b000);
    wr32(DATA_OFF, 32'h0000_0077);
    expect_rx(8'h5A);
    expect_rx(8'hC3);
    cycles(400); check32(rxq.size(), 0);
    $display("test disable done");
    wr32(CMD_OFF, 1 << C_ENABLE);
    for (int i = 0; i < 3; i++) wr32(DATA_OFF, 32'h0000_00E1);
    wait_fall; cycles(40);
    wr32(CMD_OFF, 1 << C_RESET);
    cycles(1); count_lows(300); check32(lows, 0);
    wr32(DATA_OFF, 32'h0000_0012);
    rd32(STATUS_OFF); check32(rd[11:0], 12'h000);
    $display("test reset done");
    wr32(CMD_OFF, 1 << C_BRK_START);
    cycles(4); check1(serial_out, 1'b0);
    rd32(STATUS_OFF); check1(rd[S_BREAK], 1'b1);
    wr32(CMD_OFF, 1 << C_BRK_STOP);
    cycles(4); check1(serial_out, 1'b1);
    cycles(200);
    rxq.delete();
    $display("test break done");
    wr32(DIV_OFF, 32'h0000_0003);
    bitc <= 16'h0040;
    wr32(CMD_OFF, 1 << C_ENABLE);
    wr32(DATA_OFF, 32'h0000_0099);
    wr32(CMD_OFF, 1 << C_DISABLE);
    cycles(800); check32(rxq.size(), 0);
    $display("test early disable done");
    conclude();
  end
endmodule
